/* File: hw/iir_defines.svh */
// Register offsets, field positions and counts for the IIR sequencer
`ifndef IIR_DEFINES_SVH
`define IIR_DEFINES_SVH
`define REG_STATUS 3'h0
`define REG_MASK 3'h1
`define REG_CTRL 3'h2
`define REG_CADDR 3'h3
`define REG_CDATA 3'h4
`define REG_INFO 3'h5
`define EV_ERR 0
`define EV_OUT 1
`define EV_IN 2
`define MODE_MSB 1
`define MODE_LSB 0
`define ORD_MSB 7
`define ORD_LSB 4
`define CADDR_MSB 6
`define BQ_LAST 3'h4
`define ZERO_IDX 5'h00
`define FF_BASE 5'h01
`define FB_BASE 5'h10
`define OUT_MSB 30
`define OUT_LSB 15
`endif

/* File: hw/iir_pkg.sv */
// Types shared by the IIR sequencer
package iir_pkg;
  typedef enum logic [2:0] {
    ST_SYNC, ST_RUN, ST_IN_WAIT, ST_WR_X, ST_MAC, ST_WR_Y, ST_OUT_WAIT, ST_HALT
  } state_t;
  typedef enum logic [1:0] {MODE_BIQUAD, MODE_DIRECT, MODE_CANON, MODE_SPARE} mode_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic [1:0] spare;
    logic [1:0] sel;
    logic shx;
    logic shy;
    logic clr;
    logic mac;
    logic in_en_n;
    logic out_en_n;
    logic ram_we;
    logic zcoef;
    logic take;
    logic done;
    logic err;
    logic binc;
  } ctrl_t;
  typedef struct packed {
    state_t st;
    mode_t mode;
    logic [3:0] order;
    logic [2:0] step;
    logic [3:0] k;
    logic ph;
    logic cph;
    logic fst;
    logic [34:0] acc;
    logic [15:0] xin;
    logic [3:0][1:0][7:0] stor;
    logic [15:0][15:0] ram;
    logic [3:0] base;
    logic [127:0][15:0] coef;
    logic [1:0] set;
    logic [6:0] caddr;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [15:0] out_data;
    logic out_rdy;
    logic in_tkn;
    logic err;
    logic irq;
    ctrl_t ctrl;
    logic [15:0] rdata;
  } core_t;
endpackage

/* File: hw/iir_filter_mac_sequencer.sv */
// IIR filter microcode sequencer with multiply-accumulate datapath
//
// Strobed register access and the register offsets were left to the implementer.
`include "iir_defines.svh"
// How it works
// - Output is weighted inputs minus weighted outputs
// - Signed 16x16 products into 35-bit accumulator
// - Sequencer drives sixteen registered control outputs
// - Four 8-bit-sliced registers, any one selectable
// - Chains hold two past inputs, two outputs
// - Feedback weights stored negated, always added
// - Strapped set select picks one of four
// - Oldest data multiplied first
// - Cascade section signals taken and ready, no waiting in biquad mode
// - Biquad missing input or untaken output sets error
// - Biquad yields one output per five clocks
// - Two complementary enables isolate input during biquad writeback
// - Handshake waits accumulate zero coefficient products
// - Direct mode spends two cycles writing samples, canonical one
// - RAM address is base minus logical position
// - Each RAM-mode input read increments the base counter
// - Canonical mode stores intermediates in sixteen words
module iir_filter_mac_sequencer
  import iir_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic rst,
  // Register port
  input bus_req_t bus,
  output logic [15:0] rdata_ff,
  // Coefficient set strap
  input logic [1:0] set_strap,
  // Sample input
  input logic [15:0] in_data,
  input logic in_valid,
  output logic in_taken_ff,
  // Result output
  output logic [15:0] out_data_ff,
  output logic out_ready_ff,
  input logic out_taken,
  // Controller outputs and status
  output ctrl_t ctrl_ff,
  output logic error_ff,
  output logic irq_ff
);

  core_t core_ff;
  core_t nxt_core;
  ctrl_t c;
  logic signed [15:0] opnd;
  logic signed [15:0] cf;
  logic signed [31:0] prod;
  logic [34:0] bias;
  logic [34:0] sum;
  logic [15:0] ynew;
  logic [4:0] ci;
  logic [3:0] wad;
  logic [3:0] rad;
  logic last;
  logic canon;

  assign canon = (core_ff.mode == MODE_CANON);

  always_comb begin
    nxt_core = core_ff;
    c = '0;
    c.out_en_n = 1'b1;
    opnd = '0;
    ci = `ZERO_IDX;
    bias = '0;
    wad = '0;
    rad = '0;
    last = 1'b0;
    unique case (core_ff.st)
      ST_SYNC: begin
        c.clr = 1'b1;
        if (core_ff.mode != MODE_BIQUAD) begin
          nxt_core.st = ST_IN_WAIT;
        end else if (in_valid) begin
          last = 1'b1;
        end
      end
      ST_RUN: begin
        c.mac = 1'b1;
        unique case (core_ff.step)
          3'h0: begin
            c.sel = 2'h1;
            ci = `FF_BASE + 5'h02;
            c.clr = 1'b1;
            c.shy = 1'b1;
            c.in_en_n = 1'b1;
            c.out_en_n = 1'b0;
          end
          3'h1: begin
            c.sel = 2'h3;
            ci = `FB_BASE + 5'h02;
          end
          3'h2: begin
            c.sel = 2'h0;
            ci = `FF_BASE + 5'h01;
          end
          3'h3: begin
            c.sel = 2'h2;
            ci = `FB_BASE + 5'h01;
          end
          default: begin
            last = 1'b1;
          end
        endcase
        opnd = signed'(core_ff.stor[c.sel]);
        nxt_core.step = core_ff.step + 3'h1;
      end
      ST_IN_WAIT: begin
        c.mac = 1'b1;
        c.zcoef = 1'b1;
        if (core_ff.mode == MODE_BIQUAD) begin
          nxt_core.st = ST_SYNC;
        end else if (in_valid) begin
          c.take = 1'b1;
          c.binc = 1'b1;
          nxt_core.xin = in_data;
          nxt_core.k = core_ff.order;
          nxt_core.ph = 1'b0;
          nxt_core.cph = 1'b0;
          nxt_core.fst = 1'b1;
          nxt_core.st = canon ? ST_MAC : ST_WR_X;
        end
      end
      ST_WR_X: begin
        c.ram_we = 1'b1;
        wad = canon ? core_ff.base : {1'b0, core_ff.base[2:0]};
        nxt_core.k = core_ff.order;
        nxt_core.cph = 1'b1;
        nxt_core.fst = 1'b1;
        nxt_core.st = ST_MAC;
      end
      ST_MAC: begin
        c.mac = 1'b1;
        c.clr = core_ff.fst;
        nxt_core.fst = 1'b0;
        if (canon) begin
          rad = core_ff.base - core_ff.k;
          ci = (core_ff.cph ? `FF_BASE : `FB_BASE) + {1'b0, core_ff.k};
          if (core_ff.fst && !core_ff.cph) begin
            bias = {{4{core_ff.xin[15]}}, core_ff.xin, 15'h0000};
          end
          if (core_ff.cph ? (core_ff.k == 4'h0) : (core_ff.k == 4'h1)) begin
            nxt_core.st = core_ff.cph ? ST_WR_Y : ST_WR_X;
          end else begin
            nxt_core.k = core_ff.k - 4'h1;
          end
        end else begin
          rad = {core_ff.ph, core_ff.base[2:0] - core_ff.k[2:0]};
          ci = (core_ff.ph ? `FB_BASE : `FF_BASE) + {1'b0, core_ff.k};
          if (!core_ff.ph && core_ff.k != 4'h0) begin
            nxt_core.ph = 1'b1;
          end else if (core_ff.ph) begin
            nxt_core.ph = 1'b0;
            nxt_core.k = core_ff.k - 4'h1;
          end else begin
            nxt_core.st = ST_WR_Y;
          end
        end
        opnd = signed'(core_ff.ram[rad]);
      end
      ST_WR_Y: begin
        c.done = 1'b1;
        nxt_core.st = ST_OUT_WAIT;
        if (!canon) begin
          c.ram_we = 1'b1;
          wad = {1'b1, core_ff.base[2:0]};
        end
      end
      ST_OUT_WAIT: begin
        c.mac = 1'b1;
        c.zcoef = 1'b1;
        if (!core_ff.out_rdy) begin
          nxt_core.st = ST_IN_WAIT;
        end
      end
      ST_HALT: begin
        nxt_core.st = ST_HALT;
      end
    endcase

    if (last) begin
      c.mac = 1'b1;
      c.take = 1'b1;
      c.shx = 1'b1;
      c.done = 1'b1;
      opnd = signed'(in_data);
      ci = `FF_BASE;
      nxt_core.step = '0;
      nxt_core.st = ST_RUN;
      if (!in_valid || (core_ff.out_rdy && !out_taken)) begin
        c.err = 1'b1;
        nxt_core.st = ST_HALT;
      end
    end

    cf = signed'(core_ff.coef[{core_ff.set, ci}]);
    prod = opnd * cf;
    sum = (c.clr ? bias : core_ff.acc) + {{3{prod[31]}}, prod};
    ynew = sum[`OUT_MSB:`OUT_LSB];
    if (c.mac) begin
      nxt_core.acc = sum;
    end
    if (c.shx) begin
      nxt_core.stor[1] = core_ff.stor[0];
      nxt_core.stor[0] = in_data;
    end
    if (c.shy) begin
      nxt_core.stor[3] = core_ff.stor[2];
      nxt_core.stor[2] = core_ff.out_data;
    end
    if (c.binc) begin
      nxt_core.base = core_ff.base + 4'h1;
    end
    if (c.ram_we) begin
      nxt_core.ram[wad] = (core_ff.st == ST_WR_X && !canon) ? core_ff.xin : ynew;
    end

    if (out_taken) begin
      nxt_core.out_rdy = 1'b0;
    end
    if (c.done) begin
      nxt_core.out_rdy = 1'b1;
      nxt_core.out_data = ynew;
    end
    if (c.err) begin
      nxt_core.err = 1'b1;
    end
    nxt_core.in_tkn = c.take;
    nxt_core.ctrl = c;

    nxt_core.rdata = '0;
    if (bus.wr) begin
      case (bus.addr)
        `REG_STATUS: nxt_core.stat = core_ff.stat & ~bus.wdata[2:0];
        `REG_MASK: nxt_core.mask = bus.wdata[2:0];
        `REG_CTRL: begin
          nxt_core.mode = mode_t'(bus.wdata[`MODE_MSB:`MODE_LSB]);
          nxt_core.order = bus.wdata[`ORD_MSB:`ORD_LSB];
        end
        `REG_CADDR: nxt_core.caddr = bus.wdata[`CADDR_MSB:0];
        `REG_CDATA: begin
          if (core_ff.caddr[4:0] != `ZERO_IDX) begin
            nxt_core.coef[core_ff.caddr] = bus.wdata;
          end
        end
        default: begin
        end
      endcase
    end
    // Set after clear, so a late event survives
    if (c.err) begin
      nxt_core.stat[`EV_ERR] = 1'b1;
    end
    if (c.done) begin
      nxt_core.stat[`EV_OUT] = 1'b1;
    end
    if (c.take) begin
      nxt_core.stat[`EV_IN] = 1'b1;
    end
    nxt_core.irq = |(nxt_core.stat & nxt_core.mask);

    if (bus.rd) begin
      case (bus.addr)
        `REG_STATUS: nxt_core.rdata = {13'h0000, core_ff.stat};
        `REG_MASK: nxt_core.rdata = {13'h0000, core_ff.mask};
        `REG_CTRL: nxt_core.rdata = {8'h00, core_ff.order, 2'h0, core_ff.mode};
        `REG_CADDR: nxt_core.rdata = {9'h000, core_ff.caddr};
        `REG_CDATA: nxt_core.rdata = core_ff.coef[core_ff.caddr];
        `REG_INFO: begin
          nxt_core.rdata = {8'h00, core_ff.base, 1'b0, core_ff.err, core_ff.set};
        end
        default: nxt_core.rdata = '0;
      endcase
    end
  end

  // Strap is caught by the clocked reset, never asynchronously
  always_ff @(posedge clk) begin
    if (rst) begin
      core_ff <= '0;
      core_ff.set <= set_strap;
    end else begin
      core_ff <= nxt_core;
    end
  end

  assign rdata_ff = core_ff.rdata;
  assign in_taken_ff = core_ff.in_tkn;
  assign out_data_ff = core_ff.out_data;
  assign out_ready_ff = core_ff.out_rdy;
  assign ctrl_ff = core_ff.ctrl;
  assign error_ff = core_ff.err;
  assign irq_ff = core_ff.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_bq_rate;
    ctrl_ff.done && !ctrl_ff.err && core_ff.st == ST_RUN |-> ##5 ctrl_ff.done;
  endproperty
  a_bq_rate: assert property (p_bq_rate) else $error("biquad output gap not five");

  property p_no_input;
    core_ff.st == ST_RUN && core_ff.step == `BQ_LAST && !in_valid |=> error_ff;
  endproperty
  a_no_input: assert property (p_no_input) else $error("missing input not flagged");

  property p_untaken;
    core_ff.st == ST_RUN && core_ff.step == `BQ_LAST && out_ready_ff && !out_taken
      |=> error_ff;
  endproperty
  a_untaken: assert property (p_untaken) else $error("untaken output not flagged");

  property p_halt;
    error_ff |=> error_ff && core_ff.st == ST_HALT && !ctrl_ff.done;
  endproperty
  a_halt: assert property (p_halt) else $error("error did not halt");

  property p_enables;
    ctrl_ff.shy |-> ctrl_ff.in_en_n && !ctrl_ff.out_en_n;
  endproperty
  a_enables: assert property (p_enables) else $error("enables not complementary");

  // Reset word has both enables low, so skip the first cycle
  property p_enables_pair;
    !$past(rst) |-> ctrl_ff.in_en_n != ctrl_ff.out_en_n;
  endproperty
  a_enables_pair: assert property (p_enables_pair) else $error("enables not paired");

  property p_zero_wait;
    core_ff.st == ST_IN_WAIT && !in_valid |=> $stable(core_ff.acc);
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("wait changed accumulator");

  property p_zero_hold;
    core_ff.st == ST_OUT_WAIT |=> $stable(core_ff.acc);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("result wait moved acc");

  property p_base_inc;
    in_taken_ff && core_ff.st != ST_RUN && core_ff.st != ST_HALT
      |-> core_ff.base == 4'($past(core_ff.base) + 4'h1);
  endproperty
  a_base_inc: assert property (p_base_inc) else $error("base not advanced");

  property p_write_idle;
    ctrl_ff.ram_we |-> !ctrl_ff.mac && $stable(core_ff.acc);
  endproperty
  a_write_idle: assert property (p_write_idle) else $error("compute during write");

  property p_taken;
    out_ready_ff && out_taken && !ctrl_ff.done |=> !out_ready_ff || ctrl_ff.done;
  endproperty
  a_taken: assert property (p_taken) else $error("taken output still ready");

endmodule

/* File: verification/iir_stream_partner.sv */
// Sample source and result sink on the far side of the sequencer
module iir_stream_partner (
  // Clock and reset
  input logic clk,
  input logic rst,
  // Bench control
  input logic stop,
  // From the section
  input logic in_taken_ff,
  input logic out_ready_ff,
  // To the section
  output logic [15:0] in_data,
  output logic in_valid,
  output logic out_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] k;
  always_ff @(posedge clk) begin
    if (rst) begin
      k <= 16'h0000;
      in_data <= 16'h0000;
      in_valid <= 1'b0;
      out_taken <= 1'b0;
    end else begin
      in_valid <= !stop;
      k <= k + 16'(in_taken_ff);
      // Released bus shows inverted data, not stale data
      in_data <= stop ? ~in_data : 16'((k + 16'(in_taken_ff)) * 16'h0700 - 16'h1800);
      out_taken <= out_ready_ff && !out_taken;
    end
  end
endmodule

/* File: verification/iir_filter_mac_sequencer_tb_top.sv */
// Self-checking bench for the IIR sequencer
`include "iir_defines.svh"
module iir_filter_mac_sequencer_tb_top
  import iir_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic signed [15:0] A0 = 16'sh4000;
  localparam logic signed [15:0] A1 = 16'sh2000;
  localparam logic signed [15:0] A2 = 16'sh1000;
  localparam logic signed [15:0] NB1 = 16'shE000;
  localparam logic signed [15:0] NB2 = 16'sh0800;
  logic clk, rst, in_valid, in_taken_ff, out_ready_ff, out_taken, error_ff, irq_ff, stop;
  bus_req_t bus;
  logic [15:0] rdata_ff, in_data, out_data_ff;
  logic [1:0] set_strap;
  ctrl_t ctrl_ff;
  int n_mismatch, total_checks;

  iir_filter_mac_sequencer u_dut (.clk(clk), .rst(rst), .bus(bus), .rdata_ff(rdata_ff),
    .set_strap(set_strap), .in_data(in_data), .in_valid(in_valid), .in_taken_ff(in_taken_ff),
    .out_data_ff(out_data_ff), .out_ready_ff(out_ready_ff), .out_taken(out_taken),
    .ctrl_ff(ctrl_ff), .error_ff(error_ff), .irq_ff(irq_ff));
  iir_stream_partner u_partner (.clk(clk), .rst(rst), .stop(stop), .in_taken_ff(in_taken_ff),
    .out_ready_ff(out_ready_ff), .in_data(in_data), .in_valid(in_valid), .out_taken(out_taken));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic conclude();
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus <= '0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk) bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus <= '0;
    #1 d = rdata_ff;
  endtask

  task automatic reset_dut();
    @(posedge clk) rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask

  function automatic logic [15:0] expect_y(input logic signed [15:0] p0, input logic signed [15:0] p1,
      input logic signed [15:0] p2, input logic signed [15:0] q1, input logic signed [15:0] q2);
    logic signed [34:0] acc;
    acc = A0 * p0 + A1 * p1 + A2 * p2 + NB1 * q1 + NB2 * q2;
    return acc[30:15];
  endfunction

  // Coefficients go to the strapped set; canonical reads a1 at 17, b0 b1 at 1 2
  task automatic load_coefs(input logic full);
    wr(`REG_CADDR, {9'h000, set_strap, 5'h01});
    wr(`REG_CDATA, A0);
    wr(`REG_CADDR, {9'h000, set_strap, 5'h02});
    wr(`REG_CDATA, A1);
    wr(`REG_CADDR, {9'h000, set_strap, 5'h11});
    wr(`REG_CDATA, NB1);
    wr(`REG_CADDR, {9'h000, set_strap, 5'h03});
    wr(`REG_CDATA, full ? A2 : 16'h0000);
    wr(`REG_CADDR, {9'h000, set_strap, 5'h12});
    wr(`REG_CDATA, full ? NB2 : 16'h0000);
  endtask

  task automatic wait_take(output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      #1 cyc++;
    end while (in_taken_ff !== 1'b1 && cyc < 60);
  endtask

  task automatic scen_regs();
    logic [15:0] d;
    wr(`REG_CADDR, 16'h0021);
    wr(`REG_CDATA, 16'h1234);
    rd(`REG_CDATA, d);
    chk("coef readback", 16'h1234, d);
    wr(`REG_CADDR, 16'h0020);
    wr(`REG_CDATA, 16'h5555);
    rd(`REG_CDATA, d);
    chk("zero coef", 16'h0000, d);
    rd(3'h6, d);
    chk("unmapped read", 16'h0000, d);
    rd(`REG_INFO, d);
    chk("strap set", 16'h0001, d & 16'h0003);
  endtask

  // Streams n samples; biquad checks spacing, every mode checks ready latency (zero in biquad, five in RAM modes)
  task automatic run(input mode_t m, input int n);
    logic signed [15:0] x0, x1, x2, y0, y1, y2, z0, z1;
    logic signed [34:0] za;
    logic bq;
    int cyc, lat;
    bq = (m == MODE_BIQUAD);
    {x1, x2, y1, y2, z1} = '0;
    for (int k = 0; k < n; k++) begin
      wait_take(cyc);
      x0 = 16'(k * 16'h0700 - 16'h1800);
      // Canonical: z is input plus weighted past z, output weighs z
      za = x0 * 35'sh8000 + NB1 * z1;
      z0 = za[30:15];
      if (m == MODE_CANON) y0 = expect_y(z0, z1, 16'sh0000, 16'sh0000, 16'sh0000);
      else y0 = expect_y(x0, x1, bq ? x2 : 16'sh0000, y1, bq ? y2 : 16'sh0000);
      if (bq && k > 0) chk("take spacing", 16'h0005, 16'(cyc));
      if (bq) chk("done pulse", 16'h0001, 16'(ctrl_ff.done));
      lat = 0;
      while (out_ready_ff !== 1'b1 && lat < 40) begin
        @(posedge clk);
        #1 lat++;
      end
      chk("ready latency", bq ? 16'h0000 : 16'h0005, 16'(lat));
      chk("output", y0, out_data_ff);
      {x2, x1, y2, y1, z1} = {x1, x0, y1, y0, z0};
    end
  endtask

  task automatic scen_error();
    logic [15:0] d;
    int cyc;
    wr(`REG_MASK, 16'h0001);
    @(posedge clk) stop <= 1'b1;
    cyc = 0;
    while (error_ff !== 1'b1 && cyc < 20) begin
      @(posedge clk);
      #1 cyc++;
    end
    chk("error flag", 16'h0001, 16'(error_ff));
    chk("irq raised", 16'h0001, 16'(irq_ff));
    rd(`REG_STATUS, d);
    chk("status error", 16'h0001, d & 16'h0001);
    wr(`REG_STATUS, 16'h0001);
    rd(`REG_STATUS, d);
    chk("status cleared", 16'h0000, d & 16'h0001);
    chk("irq cleared", 16'h0000, 16'(irq_ff));
    @(posedge clk) stop <= 1'b0;
    wait_take(cyc);
    chk("halted", 16'h003C, 16'(cyc));
    chk("error sticky", 16'h0001, 16'(error_ff));
  endtask

  initial begin
    rst = 1'b1;
    bus = '0;
    set_strap = 2'h1;
    stop = 1'b1;
    n_mismatch = 0;
    total_checks = 0;
    reset_dut();
    scen_regs();
    load_coefs(1'b1);
    @(posedge clk) stop <= 1'b0;
    run(MODE_BIQUAD, 6);
    scen_error();
    @(posedge clk) stop <= 1'b1;
    reset_dut();
    load_coefs(1'b0);
    wr(`REG_CTRL, 16'h0011);
    @(posedge clk) stop <= 1'b0;
    run(MODE_DIRECT, 4);
    @(posedge clk) stop <= 1'b1;
    set_strap <= 2'h2;
    reset_dut();
    load_coefs(1'b0);
    wr(`REG_CTRL, 16'h0012);
    @(posedge clk) stop <= 1'b0;
    run(MODE_CANON, 4);
    conclude();
  end

  // Hang guard, well beyond the expected run
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule
